// >>> shared/cds_pkg.sv
/*
 Constants, field layouts and carrier types shared by the character
 display core and its row drive sequencer.
 Assumes a 200 MHz mclk and a 32-bit AHB-Lite register bus.
*/
package cds_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int ON_LV_MS = 100;
   localparam int ON_5V_MS = 200;
   localparam int ON_LV_CYC = ON_LV_MS * 1000 * CLK_MHZ;
   localparam int ON_5V_CYC = ON_5V_MS * 1000 * CLK_MHZ;
   localparam int ON_CNT_W = 26;
   localparam int BUSY_CYC = 4;
   localparam int TICK_DIV = 4;
   localparam logic [7:0] K0_TICKS = 8'h7e;
   localparam logic [4:0] DIS_RST = 5'h12;
   localparam logic [3:0] PRE_RST = 4'h7;
   localparam logic [4:0] ROW_LAST = 5'h1f;
   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_TIMING = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam int CFG_EXT = 0;
   localparam int CFG_SPC = 1;
   localparam int CFG_IO5V = 2;
   localparam int CFG_LINES = 3;
   localparam int CFG_DIR_UP = 5;
   localparam int CFG_CUR = 6;
   localparam int CFG_BLINK = 7;
   localparam int CFG_INV = 8;
   localparam logic [8:0] CFG_RST = 9'h020;
   localparam logic [7:0] CONTRAST_RST = 8'h7f;
   // ---------------------------------------------------------------
   // Commands and memories
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_DISP_ON = 8'h0c;
   localparam logic [7:0] CMD_DISP_OFF = 8'h08;
   localparam logic [7:0] CMD_CONTRAST = 8'h81;
   localparam logic [1:0] CMD_GLYPH_PFX = 2'h1;
   localparam int CHAR_WORDS = 80;
   localparam int GLYPH_WORDS = 64;
   localparam logic [6:0] LINE1_LAST = 7'h4f;
   localparam logic [5:0] LINE2_LAST = 6'h27;
   localparam logic [4:0] LINE4_LAST = 5'h13;
   localparam logic [6:0] LINE2_BASE = 7'h28;
   localparam logic [6:0] LINE4_BASE = 7'h14;

   typedef struct packed {
      logic [4:0] discharge;
      logic [3:0] predrive;
   } cds_timing_t;

   typedef enum logic [2:0] {
      PH_DIS = 3'b001,
      PH_PRE = 3'b010,
      PH_CUR = 3'b100
   } cds_phase_t;
endpackage

// >>> logic/cds_row_seq.sv
/*
 Three-phase segment drive sequencer, stepped by the display tick.
 Assumes tick is a one-cycle pulse in the mclk domain.
*/
`timescale 1ns/1ps
module cds_row_seq import cds_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Control
   input wire logic tick,
   input wire cds_timing_t timing,
   // Drive state
   output cds_phase_t phase_q,
   output logic row_start_q,
   output logic [4:0] row_q
);
   cds_timing_t lat_q;
   logic [7:0] cnt_q;
   logic [7:0] len;
   logic last;

   // A zero field would stall the phase, so it counts as one tick
   always_comb begin
      len = K0_TICKS;
      unique case (phase_q)
         PH_DIS: len = (lat_q.discharge == 5'h0) ? 8'h1 :
            {3'h0, lat_q.discharge};
         PH_PRE: len = (lat_q.predrive == 4'h0) ? 8'h1 :
            {4'h0, lat_q.predrive};
         PH_CUR: len = K0_TICKS;
      endcase
   end
   assign last = tick && (cnt_q == len - 8'h1);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 8'h0;
      end else if (tick) begin
         cnt_q <= last ? 8'h0 : cnt_q + 8'h1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase_q <= PH_DIS;
      end else if (last) begin
         unique case (phase_q)
            PH_DIS: phase_q <= PH_PRE; // [RL1]
            PH_PRE: phase_q <= PH_CUR; // [RL1]
            PH_CUR: phase_q <= PH_DIS; // [RL3]
         endcase
      end
   end

   // Lengths are taken only at a row boundary so a row never mixes
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lat_q <= '{discharge: DIS_RST, predrive: PRE_RST}; // [RL20]
      end else if (last && phase_q == PH_CUR) begin
         lat_q <= timing; // [RL23]
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         row_start_q <= 1'b0;
         row_q <= 5'h0;
      end else begin
         row_start_q <= last && phase_q == PH_CUR;
         if (last && phase_q == PH_CUR) begin
            row_q <= row_q + 5'h1; // [RL3]
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   phase_order_a: assert property (@(posedge mclk) disable iff (!nrst)
      $changed(phase_q) |-> // [RL1] [RL3]
      (phase_q == PH_PRE && $past(phase_q) == PH_DIS) ||
      (phase_q == PH_CUR && $past(phase_q) == PH_PRE) ||
      (phase_q == PH_DIS && $past(phase_q) == PH_CUR))
      else $error("drive phase out of order");
   pre_length_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(phase_q == PH_CUR) |-> // [RL2]
      $past(cnt_q) == $past(len) - 8'h1 && $past(len) >= 8'h1 &&
      $past(len) <= 8'hf)
      else $error("pre-drive length wrong");
   cur_length_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(phase_q == PH_DIS) |-> $past(cnt_q) == 8'h7d) // [RL20]
      else $error("current drive length is not the fixed part");
   row_cover_c: cover property (@(posedge mclk) disable iff (!nrst)
      row_start_q && row_q == 5'h0);
endmodule

// >>> logic/cds_core.sv
/*
 Character display core: AHB-Lite register slave, instruction decode,
 busy flag, shared RAM pointer, char and glyph RAMs, line mapping,
 display on delay, contrast scaling and cursor controls.
 Assumes a single AHB-Lite master and one mclk domain.
*/
// Contract
// RL1: Rows drive discharge, pre-drive, then current.
// RL2: Pre-drive lasts 1 to 15 ticks.
// RL3: After current drive, next row repeats cycle.
// RL4: Offer 256 segment current levels.
// RL5: Contrast 0-255 by 81h, current contrast+1.
// RL6: Reset low 3us returns registers to defaults.
// RL7: 0Ch with selectors clear: on 100ms later.
// RL8: In 5V mode panel on after 200ms.
// RL9: Host sends 08h before removing power.
// RL10: Busy flag refuses instructions; host waits.
// RL11: Instruction read returns busy on bit 7.
// RL12: One pointer for both RAMs, steps by one.
// RL13: Instruction read returns pointer on bits 6:0.
// RL14: Char RAM holds 80 codes, 7-bit pointer.
// RL15: One line maps 00-4F.
// RL16: Two lines map 00-27 and 40-67.
// RL17: Three lines map 00-13, 20-33, 40-53.
// RL18: Cursor, blink and inversion controlled independently.
// RL19: Four lines add 60-73.
// RL20: Reset lengths 18 and 7 plus 126.
// RL21: Data select high is RAM data, else command.
// RL22: Busy and pointer share one read byte.
// RL23: Phase lengths are fields reloaded each row.
`timescale 1ns/1ps
module cds_core import cds_pkg::*; #(
   parameter int T_ON_LV_CYC = ON_LV_CYC,
   parameter int T_ON_5V_CYC = ON_5V_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata_q,
   output logic hreadyout_q,
   output logic hresp_q,
   // Panel side
   output logic panel_on_q,
   output cds_phase_t phase_q,
   output logic [4:0] row_q,
   output logic [8:0] seg_scale_q,
   output logic cursor_show_q,
   output logic cursor_inv_q
);
   // ---------------------------------------------------------------
   // Bus capture
   // ---------------------------------------------------------------
   logic acc, rd_acc;
   logic wr_pend_q;
   logic [7:0] wr_ofs_q;
   logic busy_q, busy_set;
   logic [2:0] busy_cnt_q;
   logic [6:0] ptr_q;
   logic glyph_sel_q;
   logic [8:0] cfg_q;
   cds_timing_t timing_q;
   logic [7:0] contrast_q;
   logic contrast_pend_q;
   logic on_arm_q;
   logic [ON_CNT_W-1:0] on_cnt_q, on_lim;
   logic [1:0] tick_cnt_q;
   logic tick_q, row_start;
   logic blink_ph_q;
   logic [7:0] char_ram [CHAR_WORDS];
   logic [7:0] glyph_ram [GLYPH_WORDS];

   // hsize is not checked: only whole-word transfers are expected
   assign acc = hsel && htrans[1] && hready;
   assign rd_acc = acc && !hwrite;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h0;
      end else begin
         wr_pend_q <= acc && hwrite;
         if (acc) begin
            wr_ofs_q <= haddr[7:0];
         end
      end
   end

   // Zero wait states and always OKAY
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Instruction decode
   // ---------------------------------------------------------------
   logic wr_cmd, wr_data, rd_data, cmd_ok;
   logic [7:0] wbyte;
   assign wbyte = hwdata[7:0];
   assign wr_cmd = wr_pend_q && wr_ofs_q == OFS_CMD && !busy_q; // [RL21]
   assign wr_data = wr_pend_q && wr_ofs_q == OFS_DATA && !busy_q;
   // A read back to back with an accepted write is refused as well
   assign rd_data = rd_acc && haddr[7:0] == OFS_DATA && !busy_q &&
      !wr_cmd && !wr_data; // [RL10]
   assign cmd_ok = !cfg_q[CFG_EXT] && !cfg_q[CFG_SPC];
   assign busy_set = wr_cmd || wr_data || rd_data;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         busy_q <= 1'b0;
         busy_cnt_q <= 3'h0;
      end else if (busy_set) begin
         busy_q <= 1'b1; // [RL10]
         busy_cnt_q <= 3'(BUSY_CYC - 1);
      end else if (busy_cnt_q != 3'h0) begin
         busy_cnt_q <= busy_cnt_q - 3'h1;
      end else begin
         busy_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Configuration and contrast
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= CFG_RST; // [RL6]
         timing_q <= '{discharge: DIS_RST, predrive: PRE_RST}; // [RL20]
      end else if (wr_pend_q && wr_ofs_q == OFS_CFG) begin
         cfg_q <= hwdata[8:0]; // [RL18]
      end else if (wr_pend_q && wr_ofs_q == OFS_TIMING) begin
         timing_q.predrive <= (hwdata[3:0] == 4'h0) ? 4'h1 :
            hwdata[3:0]; // [RL2]
         timing_q.discharge <= hwdata[8:4]; // [RL23]
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         contrast_q <= CONTRAST_RST;
         contrast_pend_q <= 1'b0;
      end else if (wr_cmd) begin
         if (contrast_pend_q) begin
            contrast_q <= wbyte; // [RL5]
            contrast_pend_q <= 1'b0;
         end else begin
            contrast_pend_q <= cfg_q[CFG_EXT] && wbyte == CMD_CONTRAST;
         end
      end
   end

   // ---------------------------------------------------------------
   // RAM pointer and memories
   // ---------------------------------------------------------------
   logic set_ptr, step;
   logic [6:0] ptr_step;
   assign set_ptr = wr_cmd && !contrast_pend_q &&
      !(cfg_q[CFG_EXT] && wbyte == CMD_CONTRAST) &&
      (wbyte[7] || wbyte[7:6] == CMD_GLYPH_PFX);
   assign step = wr_data || rd_data;
   assign ptr_step = cfg_q[CFG_DIR_UP] ? ptr_q + 7'h1 : ptr_q - 7'h1;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= 7'h0;
         glyph_sel_q <= 1'b0;
      end else if (set_ptr) begin
         ptr_q <= wbyte[7] ? wbyte[6:0] : {1'b0, wbyte[5:0]};
         glyph_sel_q <= !wbyte[7];
      end else if (step) begin
         ptr_q <= ptr_step; // [RL12]
      end
   end

   // Line mapping of the pointer, and its compact RAM index
   logic [1:0] line_idx;
   logic line_vld;
   logic [6:0] char_idx;
   always_comb begin
      line_idx = 2'h0;
      line_vld = 1'b0;
      char_idx = 7'h0;
      unique case (cfg_q[CFG_LINES+:2])
         2'h0: begin
            line_vld = ptr_q <= LINE1_LAST; // [RL15]
            char_idx = ptr_q;
         end
         2'h1: begin
            line_idx = {1'b0, ptr_q[6]};
            line_vld = ptr_q[5:0] <= LINE2_LAST; // [RL16]
            char_idx = (ptr_q[6] ? LINE2_BASE : 7'h0) + {1'b0, ptr_q[5:0]};
         end
         2'h2, 2'h3: begin
            line_idx = ptr_q[6:5];
            line_vld = ptr_q[4:0] <= LINE4_LAST && // [RL17]
               (cfg_q[CFG_LINES+:2] == 2'h3 || ptr_q[6:5] != 2'h3); // [RL19]
            char_idx = 7'(ptr_q[6:5] * LINE4_BASE) + {2'h0, ptr_q[4:0]};
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (wr_data && !glyph_sel_q && line_vld) begin
         char_ram[char_idx] <= wbyte; // [RL14]
      end
      if (wr_data && glyph_sel_q && !ptr_q[6]) begin
         glyph_ram[ptr_q[5:0]] <= wbyte; // [RL12]
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [7:0] ram_byte;
   always_comb begin
      if (glyph_sel_q) begin
         ram_byte = ptr_q[6] ? 8'h0 : glyph_ram[ptr_q[5:0]];
      end else begin
         ram_byte = line_vld ? char_ram[char_idx] : 8'h0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hrdata_q <= 32'h0;
      end else if (rd_acc) begin // [RL22]
         unique case (haddr[7:0])
            OFS_CMD: hrdata_q <= {24'h0, busy_q, ptr_q}; // [RL11] [RL13]
            OFS_DATA: hrdata_q <= rd_data ? {24'h0, ram_byte} : 32'h0;
            OFS_CFG: hrdata_q <= {23'h0, cfg_q};
            OFS_TIMING: hrdata_q <= {23'h0, timing_q};
            OFS_STAT: hrdata_q <= {16'h0, contrast_q, panel_on_q,
               on_arm_q, line_vld, line_idx, phase_q};
            default: hrdata_q <= 32'h0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Display on delay, immediate off
   // ---------------------------------------------------------------
   assign on_lim = cfg_q[CFG_IO5V] ? ON_CNT_W'(T_ON_5V_CYC - 1) :
      ON_CNT_W'(T_ON_LV_CYC - 1);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         on_arm_q <= 1'b0;
         on_cnt_q <= '0;
         panel_on_q <= 1'b0;
      end else if (wr_cmd && cmd_ok && wbyte == CMD_DISP_OFF) begin
         on_arm_q <= 1'b0; // [RL9]
         panel_on_q <= 1'b0;
      end else if (wr_cmd && cmd_ok && wbyte == CMD_DISP_ON &&
         !panel_on_q) begin
         on_arm_q <= 1'b1; // [RL7]
         on_cnt_q <= '0;
      end else if (on_arm_q) begin
         if (on_cnt_q == on_lim) begin
            on_arm_q <= 1'b0;
            panel_on_q <= 1'b1; // [RL7] [RL8]
         end else begin
            on_cnt_q <= on_cnt_q + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Display tick and row drive
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_q <= 2'h0;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 2'h1;
         tick_q <= tick_cnt_q == 2'(TICK_DIV - 1);
      end
   end

   cds_row_seq u_seq (
      .mclk(mclk),
      .nrst(nrst),
      .tick(tick_q),
      .timing(timing_q),
      .phase_q(phase_q),
      .row_start_q(row_start),
      .row_q(row_q)
   );

   // Current flows only in the current phase, scaled by contrast+1
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         seg_scale_q <= 9'h0;
      end else if (panel_on_q && phase_q == PH_CUR) begin
         seg_scale_q <= {1'b0, contrast_q} + 9'h1; // [RL4] [RL5]
      end else begin
         seg_scale_q <= 9'h0;
      end
   end

   // Blink toggles once per frame; a frame is 32 rows
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         blink_ph_q <= 1'b0;
         cursor_show_q <= 1'b0;
         cursor_inv_q <= 1'b0;
      end else begin
         if (row_start && row_q == ROW_LAST) begin
            blink_ph_q <= !blink_ph_q;
         end
         cursor_show_q <= panel_on_q && cfg_q[CFG_CUR] && // [RL18]
            (!cfg_q[CFG_BLINK] || blink_ph_q);
         cursor_inv_q <= panel_on_q && cfg_q[CFG_INV]; // [RL18]
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   status_read_a: assert property (@(posedge mclk) disable iff (!nrst)
      rd_acc && haddr[7:0] == OFS_CMD |=> // [RL11] [RL13] [RL22]
      hrdata_q == {24'h0, $past(busy_q), $past(ptr_q)})
      else $error("instruction read byte wrong");
   busy_refuse_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_pend_q && busy_q && wr_ofs_q != OFS_CFG &&
      wr_ofs_q != OFS_TIMING |=> // [RL10]
      $stable(ptr_q) && $stable(contrast_q) && !$rose(on_arm_q))
      else $error("instruction taken while busy");
   busy_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      busy_set |=> busy_q [*4]) // [RL10]
      else $error("busy flag dropped early");
   ptr_step_a: assert property (@(posedge mclk) disable iff (!nrst)
      step && !set_ptr |=> ptr_q == ($past(cfg_q[CFG_DIR_UP]) ? // [RL12]
      $past(ptr_q) + 7'h1 : $past(ptr_q) - 7'h1))
      else $error("pointer did not step by one");
   on_delay_a: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(panel_on_q) |-> $past(on_arm_q) && // [RL7] [RL8]
      $past(on_cnt_q) == $past(on_lim))
      else $error("panel enabled at the wrong time");
   disp_off_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_cmd && cmd_ok && wbyte == CMD_DISP_OFF |=> !panel_on_q) // [RL9]
      else $error("panel still on after off command");
   scale_a: assert property (@(posedge mclk) disable iff (!nrst)
      seg_scale_q != 9'h0 |-> // [RL4] [RL5]
      seg_scale_q == {1'b0, $past(contrast_q)} + 9'h1)
      else $error("segment scale not contrast plus one");
   map_two_a: assert property (@(posedge mclk) disable iff (!nrst)
      cfg_q[CFG_LINES+:2] == 2'h1 && ptr_q >= 7'h40 &&
      ptr_q <= 7'h67 |-> line_vld && line_idx == 2'h1) // [RL16]
      else $error("two-line mapping wrong");
   on_cover_c: cover property (@(posedge mclk) disable iff (!nrst)
      $rose(panel_on_q));
   contrast_cover_c: cover property (@(posedge mclk) disable iff (!nrst)
      wr_cmd && contrast_pend_q);
   data_cover_c: cover property (@(posedge mclk) disable iff (!nrst)
      wr_data ##[1:20] rd_data);
endmodule

// >>> verif/cds_host.sv
/*
 Host controller model: an AHB-Lite master with single word transfers.
 Assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module cds_host import cds_pkg::*; (
   // Clock
   input wire logic mclk,
   // AHB-Lite master
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Finished reads
   output logic [31:0] rdata,
   output int rcnt
);
   initial begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rdata = 32'h0;
      rcnt = 0;
   end

   // ---------------------------------------------------------------
   // Bus cycles, entered just after a rising edge
   // ---------------------------------------------------------------
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, input logic chk,
                       output logic [31:0] rd);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
      // A released data bus must not keep showing the old word
      hwdata <= ~wd;
      if (chk) begin
         rdata <= hrdata;
         rcnt <= rcnt + 1;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(a, 1'b1, d, 1'b0, x);
   endtask

   // Next instruction only once the pending flag reads low
   task automatic idle();
      logic [31:0] s;
      int k;
      k = 0;
      do begin
         xfer(OFS_CMD, 1'b0, 32'h0, 1'b0, s);
         k++;
      end while (s[7] !== 1'b0 && k < 64);
      if (s[7] !== 1'b0) begin
         cds_core_tb.err_total++;
         $display("ERROR %0t pending flag never cleared", $time);
      end
   endtask
endmodule

// >>> verif/cds_core_tb.sv
/*
 Self-checking bench for the character display core.
 Assumes the host model owns the bus; reads are checked from a queue.
*/
`timescale 1ns/1ps
module cds_core_tb import cds_pkg::*;;
   localparam int T_LV = 50;
   localparam int T_5V = 100;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic hsel, hwrite, hreadyout_q, hresp_q, panel_on_q;
   logic cursor_show_q, cursor_inv_q;
   logic [31:0] haddr, hwdata, hrdata_q, rdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] row_q, r;
   logic [8:0] seg_scale_q;
   logic [7:0] d[4];
   logic [6:0] in_a[4] = '{7'h4f, 7'h67, 7'h53, 7'h73};
   logic [6:0] out_a[4] = '{7'h50, 7'h28, 7'h60, 7'h74};
   logic [8:0] tm[3] = '{9'h127, 9'h011, 9'h1ff};
   cds_phase_t phase_q;
   int rcnt, err_total, comparisons, seed, i, j, n;
   logic [31:0] expq[$];

   always #2.5 mclk = ~mclk;

   // ---------------------------------------------------------------
   // Design and host
   // ---------------------------------------------------------------
   cds_core #(.T_ON_LV_CYC(T_LV), .T_ON_5V_CYC(T_5V)) u_cds_core (
      .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout_q), .hrdata_q(hrdata_q),
      .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
      .panel_on_q(panel_on_q), .phase_q(phase_q), .row_q(row_q),
      .seg_scale_q(seg_scale_q), .cursor_show_q(cursor_show_q),
      .cursor_inv_q(cursor_inv_q));
   cds_host u_cds_host (
      .mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout_q), .hrdata(hrdata_q), .rdata(rdata),
      .rcnt(rcnt));

   // ---------------------------------------------------------------
   // Checking
   // ---------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(rcnt) begin
      cmp(rdata, expq.pop_front());
      cmp({31'h0, hresp_q}, 32'h0);
   end

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      expq.push_back(e);
      u_cds_host.xfer(a, 1'b0, 32'h0, 1'b1, x);
   endtask

   task automatic wi(input logic [7:0] a, input logic [31:0] w);
      u_cds_host.wr(a, w);
      u_cds_host.idle();
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask

   // Cycles until phase_q leaves (keep) or reaches (!keep) ph
   task automatic span(input cds_phase_t ph, input bit keep,
                       output int c);
      c = 0;
      while ((phase_q === ph) == keep && c < 4000) begin
         settle(1);
         c++;
      end
   endtask

   initial begin
      repeat (90000) @(posedge mclk);
      err_total++;
      $display("ERROR %0t watchdog expired", $time);
      summarize();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      seed = 6810;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rdc(OFS_CMD, 32'h0);
      rdc(OFS_CFG, 32'h020);
      rdc(OFS_TIMING, 32'h127);
      for (i = 0; i < 3; i++) begin
         if (i > 0)
            wi(OFS_TIMING, {23'h0, tm[i]});
         settle(1);
         span(PH_CUR, 1'b0, n);
         span(PH_CUR, 1'b1, n);
         r = row_q;
         span(PH_DIS, 1'b1, n);
         cmp(n, 4 * tm[i][8:4]);
         span(PH_PRE, 1'b1, n);
         cmp(n, 4 * tm[i][3:0]);
         span(PH_CUR, 1'b1, n);
         cmp(n, 4 * 126);
         cmp(row_q, 5'(r + 5'h1));
         @(posedge mclk);
      end
      u_cds_host.wr(OFS_CMD, 32'h90);
      rdc(OFS_CMD, 32'h90);
      u_cds_host.wr(OFS_DATA, 32'h5a);
      u_cds_host.idle();
      rdc(OFS_CMD, 32'h10);
      for (i = 0; i < 4; i++) begin
         d[i] = 8'($random(seed));
         wi(OFS_DATA, {24'h0, d[i]});
      end
      rdc(OFS_CMD, 32'h14);
      wi(OFS_CMD, 32'h90);
      for (i = 0; i < 4; i++) begin
         rdc(OFS_DATA, {24'h0, d[i]});
         u_cds_host.idle();
      end
      wi(OFS_CFG, 32'h0);
      wi(OFS_DATA, 32'h3c);
      rdc(OFS_CMD, 32'h13);
      v = {24'h0, 8'($random(seed))};
      wi(OFS_CMD, 32'h45);
      wi(OFS_DATA, v);
      wi(OFS_CMD, 32'h45);
      rdc(OFS_DATA, v);
      u_cds_host.idle();
      rdc(OFS_CMD, 32'h04);
      u_cds_host.wr(8'h20, 32'hffff_ffff);
      rdc(8'h20, 32'h0);
      for (j = 0; j < 4; j++) begin
         wi(OFS_CFG, {23'h0, CFG_RST} | (j << CFG_LINES));
         for (i = 0; i < 2; i++) begin
            v = {24'h0, 8'($random(seed))};
            n = i ? out_a[j] : in_a[j];
            wi(OFS_CMD, 32'h80 | n);
            wi(OFS_DATA, v);
            wi(OFS_CMD, 32'h80 | n);
            rdc(OFS_DATA, i ? 32'h0 : v);
            u_cds_host.idle();
         end
      end
      for (j = 0; j < 2; j++) begin
         v = j ? 32'hff : {24'h0, 8'($random(seed))};
         wi(OFS_CFG, {23'h0, CFG_RST} | 32'h1);
         wi(OFS_CMD, {24'h0, CMD_CONTRAST});
         wi(OFS_CMD, v);
         wi(OFS_CFG, {23'h0, CFG_RST} | (j << CFG_IO5V));
         u_cds_host.wr(OFS_CMD, {24'h0, CMD_DISP_OFF});
         settle(1);
         cmp(panel_on_q, 1'b0);
         @(posedge mclk);
         u_cds_host.idle();
         u_cds_host.wr(OFS_CMD, {24'h0, CMD_DISP_ON});
         settle(j ? T_5V - 1 : T_LV - 1);
         cmp(panel_on_q, 1'b0);
         settle(2);
         cmp(panel_on_q, 1'b1);
         span(PH_CUR, 1'b1, n);
         span(PH_CUR, 1'b0, n);
         settle(2);
         cmp(seg_scale_q, v + 1);
         @(posedge mclk);
      end
      wi(OFS_CFG, {23'h0, CFG_RST} | 32'h2);
      wi(OFS_CMD, {24'h0, CMD_DISP_OFF});
      settle(2);
      cmp(panel_on_q, 1'b1);
      @(posedge mclk);
      for (j = 0; j < 4; j++) begin
         wi(OFS_CFG, {23'h0, CFG_RST} | ((j & 1) << CFG_CUR)
            | ((j >> 1) << CFG_INV));
         settle(1);
         cmp(cursor_show_q, j & 1);
         cmp(cursor_inv_q, j >> 1);
         @(posedge mclk);
      end
      // Blink gates the cursor once per 32-row frame
      wi(OFS_CFG, {23'h0, CFG_RST} | 32'hc0);
      for (j = 0; j < 2; j++) begin
         n = 0;
         r[0] = cursor_show_q;
         while (cursor_show_q === r[0] && n < 30000) begin
            settle(1);
            n++;
         end
      end
      cmp(n, 128 * (tm[2][8:4] + tm[2][3:0] + 126));
      nrst <= 1'b0;
      repeat (20) @(posedge mclk);
      cmp(panel_on_q, 1'b0);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rdc(OFS_CFG, {23'h0, CFG_RST});
      rdc(OFS_STAT, {16'h0, CONTRAST_RST, 8'h21});
      summarize();
   end
endmodule
